/* design/gpio_port_pkg.sv */
// Constants and types shared by the retaining GPIO port design.
package gpio_port_pkg;

   // ==========================================================
   // Sizes
   localparam int NUM_PINS = 19;
   localparam int DM_W = 3;
   localparam int SEL_W = 2;
   localparam int DM_PER_REG = 10;
   localparam int SEL_PER_REG = 16;
   localparam int FIX_W = 2;
   localparam int ST_W = 2;

   // ==========================================================
   // Drive mode encoding
   localparam logic [2:0] DM_DISABLED = 3'h0;
   localparam logic [2:0] DM_INPUT_ONLY = 3'h1;
   localparam logic [2:0] DM_WEAK_UP_STRONG_DN = 3'h2;
   localparam logic [2:0] DM_STRONG_UP_WEAK_DN = 3'h3;
   localparam logic [2:0] DM_OPEN_DRAIN_LOW = 3'h4;
   localparam logic [2:0] DM_OPEN_DRAIN_HIGH = 3'h5;
   localparam logic [2:0] DM_STRONG_BOTH = 3'h6;
   localparam logic [2:0] DM_WEAK_BOTH = 3'h7;

   // ==========================================================
   // Edge select and matrix source codes
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] MX_DATA = 2'h0;
   localparam logic [1:0] MX_PERIPH_A = 2'h1;
   localparam logic [1:0] MX_PERIPH_B = 2'h2;
   localparam logic [1:0] MX_PERIPH_C = 2'h3;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_DATA_OUT = 8'h00;
   localparam logic [7:0] OFF_PIN_STATE = 8'h04;
   localparam logic [7:0] OFF_DRIVE_LO = 8'h08;
   localparam logic [7:0] OFF_DRIVE_HI = 8'h0c;
   localparam logic [7:0] OFF_IN_DIS = 8'h10;
   localparam logic [7:0] OFF_OUT_DIS = 8'h14;
   localparam logic [7:0] OFF_LVTTL = 8'h18;
   localparam logic [7:0] OFF_SLOW_SLEW = 8'h1c;
   localparam logic [7:0] OFF_EDGE_LO = 8'h20;
   localparam logic [7:0] OFF_EDGE_HI = 8'h24;
   localparam logic [7:0] OFF_MATRIX_LO = 8'h28;
   localparam logic [7:0] OFF_MATRIX_HI = 8'h2c;
   localparam logic [7:0] OFF_PIN_FLAG = 8'h30;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h34;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h38;
   localparam logic [7:0] OFF_HOLD = 8'h3c;

   // ==========================================================
   // Field positions and reset values
   localparam int ST_PIN_EDGE = 0;
   localparam int ST_WAKE = 1;
   localparam int HOLD_EN_BIT = 0;
   localparam int HOLD_RETAIN_BIT = 1;
   localparam logic [ST_W-1:0] RST_IRQ_MASK = 2'h0;
   localparam logic RST_HOLD_EN = 1'b0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [2:0] mode;
      logic in_dis;
      logic out_dis;
      logic lvttl;
      logic slow;
   } pin_cfg_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic pull_up;
      logic pull_dn;
      logic in_en;
      logic lvttl;
      logic slow;
   } pad_ctrl_t;

endpackage

/* design/gpio_pin_cell.sv */
// One pin: drive mode decode, frozen pad controls, input sync, edge detect.
`timescale 1ns/10ps
module gpio_pin_cell
   import gpio_port_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire pin_cfg_t cfg,
   input wire logic drive_val,
   input wire logic freeze,
   input wire logic [1:0] edge_sel,
   input wire logic pin_in,
   output pad_ctrl_t pad,
   output logic level,
   output logic edge_evt
);

   pad_ctrl_t pad_next;
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;

   // ==========================================================
   // Drive mode decode
   always_comb begin
      pad_next = '0;
      pad_next.out = drive_val;
      pad_next.lvttl = cfg.lvttl;
      pad_next.slow = cfg.slow;
      pad_next.in_en = (cfg.mode != DM_DISABLED) && !cfg.in_dis;
      // eight drive modes
      // A weak pull is released while the strong driver opposes it, so no
      // current flows through the resistor into the driver.
      case (cfg.mode)
         DM_WEAK_UP_STRONG_DN: begin
            pad_next.oe = !drive_val;
            pad_next.pull_up = drive_val;
         end
         DM_STRONG_UP_WEAK_DN: begin
            pad_next.oe = drive_val;
            pad_next.pull_dn = !drive_val;
         end
         DM_OPEN_DRAIN_LOW: pad_next.oe = !drive_val;
         DM_OPEN_DRAIN_HIGH: pad_next.oe = drive_val;
         DM_STRONG_BOTH: pad_next.oe = 1'b1;
         DM_WEAK_BOTH: begin
            pad_next.pull_up = drive_val;
            pad_next.pull_dn = !drive_val;
         end
         default: pad_next.oe = 1'b0;
      endcase
      if (cfg.out_dis) begin
         pad_next.oe = 1'b0;
      end
   end

   // ==========================================================
   // Pad control flops
   // reset disables pad
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pad <= '0;
      end else if (!freeze) begin
         pad <= pad_next;
      end
   end

   // ==========================================================
   // Input synchroniser and edge detect
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         level <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         level <= sync2_reg & pad.in_en;
         prev_reg <= level;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         edge_evt <= 1'b0;
      end else begin
         edge_evt <= (edge_sel[0] & level & ~prev_reg)
            | (edge_sel[1] & ~level & prev_reg);
      end
   end

endmodule // gpio_pin_cell

/* design/gpio_port_with_retention.sv */
// Retaining GPIO port: APB registers, pin matrix, hold and interrupts.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
module gpio_port_with_retention
   import gpio_port_pkg::*;
#(
   parameter int N = NUM_PINS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic deep_sleep,
   input wire logic [N-1:0] periph_a,
   input wire logic [N-1:0] periph_b,
   input wire logic [N-1:0] periph_c,
   input wire logic [N-1:0] pin_in,
   output logic [N-1:0] pin_out,
   output logic [N-1:0] pin_oe,
   output logic [N-1:0] pin_pull_up,
   output logic [N-1:0] pin_pull_dn,
   output logic [N-1:0] pin_in_en,
   output logic [N-1:0] pin_lvttl,
   output logic [N-1:0] pin_slow_slew,
   output logic [N-1:0] pin_level,
   input wire logic [FIX_W-1:0] fixed_fn_in,
   output logic [FIX_W-1:0] fixed_fn_out,
   output logic port_irq,
   output logic irq
);

   // ==========================================================
   // Elaboration checks
   // The register split holds ten drive fields and sixteen edge and
   // matrix fields in the low word, so the pin count is bounded both ways.
   if (N <= SEL_PER_REG || N > 2 * DM_PER_REG) begin : g_bad_n
      $error("pin count out of range for register layout");
   end

   // ==========================================================
   // Declarations
   logic [N-1:0] data_out_reg, in_dis_reg, out_dis_reg, lvttl_reg, slow_reg;
   logic [N-1:0] flag_reg, flag_next, level, edge_evt, drive_val;
   logic [DM_W*N-1:0] mode_reg;
   logic [SEL_W*N-1:0] edge_reg, mx_reg;
   logic [ST_W-1:0] status_reg, status_next, status_evt, mask_reg;
   logic hold_en_reg, retain_reg, sleep_prev_reg, addr_hit, setup;
   logic acc_done, wr_acc, rd_acc, cfg_write, freeze;
   logic [31:0] rd_val;

   // ==========================================================
   // APB slave
   assign setup = psel & ~penable;
   assign acc_done = psel & penable & pready;
   assign wr_acc = acc_done & pwrite & ~pslverr;
   assign rd_acc = acc_done & ~pwrite & ~pslverr;

   // Read data and the error flag are formed in the setup cycle so that
   // every output leaves a flop; each access thus takes exactly one wait-free
   // access cycle.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~addr_hit;
         if (setup && !pwrite && addr_hit) begin
            prdata <= rd_val;
         end else if (setup) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // Read multiplexer
   always_comb begin
      rd_val = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr)
         OFF_DATA_OUT: rd_val[N-1:0] = data_out_reg;
         OFF_PIN_STATE: rd_val[N-1:0] = level;
         OFF_DRIVE_LO: rd_val[DM_W*DM_PER_REG-1:0] =
            mode_reg[DM_W*DM_PER_REG-1:0];
         OFF_DRIVE_HI: rd_val[DM_W*(N-DM_PER_REG)-1:0] =
            mode_reg[DM_W*N-1:DM_W*DM_PER_REG];
         OFF_IN_DIS: rd_val[N-1:0] = in_dis_reg;
         OFF_OUT_DIS: rd_val[N-1:0] = out_dis_reg;
         OFF_LVTTL: rd_val[N-1:0] = lvttl_reg;
         OFF_SLOW_SLEW: rd_val[N-1:0] = slow_reg;
         OFF_EDGE_LO: rd_val = edge_reg[SEL_W*SEL_PER_REG-1:0];
         OFF_EDGE_HI: rd_val[SEL_W*(N-SEL_PER_REG)-1:0] =
            edge_reg[SEL_W*N-1:SEL_W*SEL_PER_REG];
         OFF_MATRIX_LO: rd_val = mx_reg[SEL_W*SEL_PER_REG-1:0];
         OFF_MATRIX_HI: rd_val[SEL_W*(N-SEL_PER_REG)-1:0] =
            mx_reg[SEL_W*N-1:SEL_W*SEL_PER_REG];
         OFF_PIN_FLAG: rd_val[N-1:0] = flag_reg;
         OFF_IRQ_STATUS: rd_val[ST_W-1:0] = status_reg;
         OFF_IRQ_MASK: rd_val[ST_W-1:0] = mask_reg;
         OFF_HOLD: begin
            rd_val[HOLD_EN_BIT] = hold_en_reg;
            rd_val[HOLD_RETAIN_BIT] = retain_reg;
         end
         default: addr_hit = 1'b0;
      endcase
   end

   // ==========================================================
   // Data output register
   // data output
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         data_out_reg <= '0;
      end else if (wr_acc && paddr == OFF_DATA_OUT) begin
         data_out_reg <= pwdata[N-1:0];
      end
   end

   // ==========================================================
   // Pin configuration registers
   // reset to disabled
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_reg <= {N{DM_DISABLED}};
      end else if (wr_acc && paddr == OFF_DRIVE_LO) begin
         for (int i = 0; i < DM_PER_REG; i++) begin
            mode_reg[DM_W*i +: DM_W] <= pwdata[DM_W*i +: DM_W];
         end
      end else if (wr_acc && paddr == OFF_DRIVE_HI) begin
         for (int i = DM_PER_REG; i < N; i++) begin
            mode_reg[DM_W*i +: DM_W] <=
               pwdata[DM_W*(i-DM_PER_REG) +: DM_W];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_dis_reg <= '0;
         out_dis_reg <= '0;
      end else if (wr_acc && paddr == OFF_IN_DIS) begin
         in_dis_reg <= pwdata[N-1:0];
      end else if (wr_acc && paddr == OFF_OUT_DIS) begin
         out_dis_reg <= pwdata[N-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lvttl_reg <= '0;
         slow_reg <= '0;
      end else if (wr_acc && paddr == OFF_LVTTL) begin
         lvttl_reg <= pwdata[N-1:0];
      end else if (wr_acc && paddr == OFF_SLOW_SLEW) begin
         slow_reg <= pwdata[N-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         edge_reg <= '0;
      end else if (wr_acc && paddr == OFF_EDGE_LO) begin
         edge_reg[SEL_W*SEL_PER_REG-1:0] <= pwdata;
      end else if (wr_acc && paddr == OFF_EDGE_HI) begin
         edge_reg[SEL_W*N-1:SEL_W*SEL_PER_REG] <=
            pwdata[SEL_W*(N-SEL_PER_REG)-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mx_reg <= '0;
      end else if (wr_acc && paddr == OFF_MATRIX_LO) begin
         mx_reg[SEL_W*SEL_PER_REG-1:0] <= pwdata;
      end else if (wr_acc && paddr == OFF_MATRIX_HI) begin
         mx_reg[SEL_W*N-1:SEL_W*SEL_PER_REG] <=
            pwdata[SEL_W*(N-SEL_PER_REG)-1:0];
      end
   end

   // ==========================================================
   // Hold and retention
   // A write to any pin-facing register counts as software taking the
   // pins back; flag, status, mask, hold and edge-select writes do not.
   always_comb begin
      cfg_write = 1'b0;
      if (wr_acc) begin
         case (paddr)
            OFF_DATA_OUT, OFF_DRIVE_LO, OFF_DRIVE_HI, OFF_IN_DIS,
            OFF_OUT_DIS, OFF_LVTTL, OFF_SLOW_SLEW, OFF_MATRIX_LO,
            OFF_MATRIX_HI: cfg_write = 1'b1;
            default: cfg_write = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold_en_reg <= RST_HOLD_EN;
      end else if (wr_acc && paddr == OFF_HOLD) begin
         hold_en_reg <= pwdata[HOLD_EN_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         retain_reg <= 1'b0;
      end else if (hold_en_reg && deep_sleep) begin
         retain_reg <= 1'b1;
      end else if (cfg_write) begin
         retain_reg <= 1'b0;
      end
   end

   assign freeze = (hold_en_reg & deep_sleep) | retain_reg;

   // ==========================================================
   // Pin cells
   for (genvar g = 0; g < N; g++) begin : g_pin
      pin_cfg_t cfg;
      pad_ctrl_t pad;
      assign cfg = {mode_reg[DM_W*g +: DM_W], in_dis_reg[g], out_dis_reg[g],
         lvttl_reg[g], slow_reg[g]};
      always_comb begin
         case (mx_reg[SEL_W*g +: SEL_W])
            MX_PERIPH_A: drive_val[g] = periph_a[g];
            MX_PERIPH_B: drive_val[g] = periph_b[g];
            MX_PERIPH_C: drive_val[g] = periph_c[g];
            default: drive_val[g] = data_out_reg[g];
         endcase
      end

      gpio_pin_cell u_cell (
         .core_clk(core_clk),
         .rst(rst),
         .cfg(cfg),
         .drive_val(drive_val[g]),
         .freeze(freeze),
         .edge_sel(edge_reg[SEL_W*g +: SEL_W]),
         .pin_in(pin_in[g]),
         .pad(pad),
         .level(level[g]),
         .edge_evt(edge_evt[g])
      );
      assign {pin_out[g], pin_oe[g], pin_pull_up[g], pin_pull_dn[g],
         pin_in_en[g], pin_lvttl[g], pin_slow_slew[g]} = pad;
   end
   assign pin_level = level;

   // ==========================================================
   // Fixed-function pins
   // bypasses matrix
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fixed_fn_out <= '0;
      end else begin
         fixed_fn_out <= fixed_fn_in;
      end
   end

   // ==========================================================
   // Pin flags and port request
   // sticky flag, set wins
   always_comb begin
      flag_next = flag_reg;
      if (wr_acc && paddr == OFF_PIN_FLAG) begin
         flag_next = flag_reg & ~pwdata[N-1:0];
      end
      flag_next = flag_next | edge_evt;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         port_irq <= 1'b0;
      end else begin
         port_irq <= |flag_next;
      end
   end

   // ==========================================================
   // Interrupt status, mask and line
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sleep_prev_reg <= 1'b0;
      end else begin
         sleep_prev_reg <= deep_sleep;
      end
   end

   always_comb begin
      status_evt = '0;
      status_evt[ST_PIN_EDGE] = |edge_evt;
      status_evt[ST_WAKE] = sleep_prev_reg & ~deep_sleep;
   end

   // Only the bits returned by this read are cleared; a bit that rose
   // after the data was captured survives to the next read.
   always_comb begin
      status_next = status_reg;
      if (rd_acc && paddr == OFF_IRQ_STATUS) begin
         status_next = status_reg & ~prdata[ST_W-1:0];
      end
      status_next = status_next | status_evt;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mask_reg <= RST_IRQ_MASK;
      end else if (wr_acc && paddr == OFF_IRQ_MASK) begin
         mask_reg <= pwdata[ST_W-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_next & mask_reg);
      end
   end

endmodule // gpio_port_with_retention

/* bench/gpio_board.sv */
// Board model that resolves each pad from drivers, pulls and a bench source.
`timescale 1ns/10ps
module gpio_board
   import gpio_port_pkg::*;
#(
   parameter int N = NUM_PINS
) (
   input wire logic core_clk,
   input wire logic [N-1:0] pin_out,
   input wire logic [N-1:0] pin_oe,
   input wire logic [N-1:0] pin_pull_up,
   input wire logic [N-1:0] pin_pull_dn,
   input wire logic [N-1:0] ext_en,
   input wire logic [N-1:0] ext_val,
   output logic [N-1:0] pin_in
);
   // Undriven pads flip every cycle, so a stale level is never read.
   logic [N-1:0] float_reg = '0;
   always @(posedge core_clk) begin
      float_reg <= ~float_reg;
   end
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
            pin_pull_up[i] ? 1'b1 : pin_pull_dn[i] ? 1'b0 : float_reg[i];
      end
   end
endmodule // gpio_board

/* bench/gpio_port_checker.sv */
// Port-level assertions for the retaining GPIO port.
`timescale 1ns/10ps
module gpio_port_checker
   import gpio_port_pkg::*;
#(
   parameter int N = NUM_PINS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [N-1:0] pin_in,
   input wire logic [N-1:0] pin_oe,
   input wire logic [N-1:0] pin_pull_up,
   input wire logic [N-1:0] pin_pull_dn,
   input wire logic [N-1:0] pin_in_en,
   input wire logic [N-1:0] pin_level,
   input wire logic [FIX_W-1:0] fixed_fn_in,
   input wire logic [FIX_W-1:0] fixed_fn_out
);
   // ==========================================================
   // Helpers
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic unmapped;
   assign unmapped = (paddr[1:0] != 2'h0) || (paddr > OFF_HOLD);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   // ==========================================================
   // Properties
   pins_reset_a: assert property ($fell(rst) |->
      pin_oe == '0 && pin_in_en == '0 && (pin_pull_up | pin_pull_dn) == '0)
      else $error("pins not disabled after reset");
   ready_pulse_a: assert property (s_setup |=> s_answer)
      else $error("pready is not one access cycle");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access cycle");
   slverr_map_a: assert property (s_setup |=>
      pslverr == $past(unmapped))
      else $error("pslverr does not match the address map");
   slverr_zero_a: assert property (pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   fixed_path_a: assert property (!$past(rst) |->
      fixed_fn_out == $past(fixed_fn_in))
      else $error("fixed path is not one cycle");
   level_sync_a: assert property (pin_in_en == $past(pin_in_en) |->
      pin_level == ($past(pin_in, 3) & pin_in_en))
      else $error("pin level is not the synchronised pin");
   drive_excl_a: assert property (((pin_pull_up & pin_pull_dn) |
      (pin_oe & (pin_pull_up | pin_pull_dn))) == '0)
      else $error("pad drivers overlap");
endmodule // gpio_port_checker

bind gpio_port_with_retention gpio_port_checker #(.N(N)) i_chk (
   .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pin_in(pin_in), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
   .pin_pull_dn(pin_pull_dn), .pin_in_en(pin_in_en), .pin_level(pin_level),
   .fixed_fn_in(fixed_fn_in), .fixed_fn_out(fixed_fn_out));

/* bench/gpio_port_with_retention_tb.sv */
// Self-checking bench for the retaining GPIO port.
`timescale 1ns/10ps
module gpio_port_with_retention_tb;
   import gpio_port_pkg::*;
   localparam int N = NUM_PINS;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic deep_sleep = 1'b0;
   logic [N-1:0] periph_a = '0;
   logic [N-1:0] periph_b = '0;
   logic [N-1:0] periph_c = '0;
   logic [N-1:0] ext_val = '0;
   logic [N-1:0] ext_en = '0;
   logic [FIX_W-1:0] fixed_fn_in = '0;
   logic [N-1:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_dn;
   logic [N-1:0] pin_in_en, pin_lvttl, pin_slow_slew, pin_level;
   logic [FIX_W-1:0] fixed_fn_out;
   logic [31:0] prdata, q;
   logic pready, pslverr, port_irq, irq, e;
   int n_fail = 0;
   int samples_checked = 0;
   always #2.5 core_clk = ~core_clk;
   gpio_port_with_retention #(.N(N)) i_dut (
      .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .deep_sleep(deep_sleep),
      .periph_a(periph_a), .periph_b(periph_b), .periph_c(periph_c),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn),
      .pin_in_en(pin_in_en), .pin_lvttl(pin_lvttl),
      .pin_slow_slew(pin_slow_slew), .pin_level(pin_level),
      .fixed_fn_in(fixed_fn_in), .fixed_fn_out(fixed_fn_out),
      .port_irq(port_irq), .irq(irq));
   gpio_board #(.N(N)) i_board (.core_clk(core_clk), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   // ==========================================================
   // Tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h", $time, m, got);
      end
   endtask
   // Pads settle one edge after the access edge, before the task returns.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      step(2);
      if (k == 16) begin
         chk(32'h0, 32'h1, "apb timeout");
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      deep_sleep <= 1'b0;
      step(4);
      rst <= 1'b0;
      step(1);
   endtask
   // Expected {oe, pull up, pull down} for a mode and a drive value.
   function automatic logic [2:0] pad_exp(input logic [2:0] m, input logic o);
      case (m)
         DM_WEAK_UP_STRONG_DN: return o ? 3'h2 : 3'h4;
         DM_STRONG_UP_WEAK_DN: return o ? 3'h4 : 3'h1;
         DM_OPEN_DRAIN_LOW: return o ? 3'h0 : 3'h4;
         DM_OPEN_DRAIN_HIGH: return o ? 3'h4 : 3'h0;
         DM_STRONG_BOTH: return 3'h4;
         DM_WEAK_BOTH: return o ? 3'h2 : 3'h1;
         default: return 3'h0;
      endcase
   endfunction
   // ==========================================================
   // Sequence
   initial begin
      do_reset();
      for (int a = 0; a < 64; a += 4) begin
         rd(8'(a));
         chk(q, 32'h0, "reset value");
      end
      wr(8'h40, 32'hffff_ffff);
      chk(32'(e), 32'h1, "unmapped write");
      rd(8'h02);
      chk({q[30:0], e}, 32'h1, "misaligned read");
      $display("test reset and map done");
      for (int m = 0; m < 8; m++) begin
         for (int o = 0; o < 2; o++) begin
            wr(OFF_DRIVE_LO, 32'(m));
            wr(OFF_DATA_OUT, 32'(o));
            chk(32'({pin_oe[0], pin_pull_up[0], pin_pull_dn[0], pin_in_en[0]}),
               32'({pad_exp(3'(m), o[0]), m != 0}), "mode");
         end
      end
      wr(OFF_DRIVE_LO, 32'(DM_STRONG_BOTH));
      wr(OFF_OUT_DIS, 32'h1);
      wr(OFF_LVTTL, 32'h1);
      chk(32'({pin_oe[0], pin_in_en[0], pin_lvttl[0]}), 32'h3,
         "odis");
      wr(OFF_OUT_DIS, 32'h0);
      wr(OFF_IN_DIS, 32'h1);
      wr(OFF_SLOW_SLEW, 32'h1);
      chk(32'({pin_oe[0], pin_in_en[0], pin_slow_slew[0]}), 32'h5,
         "idis");
      wr(OFF_IN_DIS, 32'h0);
      wr(OFF_DRIVE_HI, 32'h0600_0000);
      wr(OFF_DATA_OUT, 32'h0004_0000);
      chk(32'({pin_oe[18], pin_out[18]}), 32'h3, "last pin");
      $display("test drive modes done");
      for (int p = 0; p < 2; p++) begin
         periph_a[0] <= ~p[0];
         periph_b[0] <= p[0];
         periph_c[0] <= ~p[0];
         wr(OFF_DATA_OUT, 32'(p));
         for (int c = 0; c < 4; c++) begin
            wr(OFF_MATRIX_LO, 32'(c));
            chk(32'(pin_out[0]), 32'(p[0] ^ c[0]), "matrix");
         end
      end
      wr(OFF_MATRIX_LO, 32'h0);
      fixed_fn_in <= 2'h2;
      step(3);
      chk(32'(fixed_fn_out), 32'h2, "fixed path");
      $display("test matrix done");
      wr(OFF_DRIVE_LO, 32'h0000_000e);
      ext_en[1] <= 1'b1;
      for (int ec = 1; ec < 4; ec++) begin
         wr(OFF_EDGE_LO, 32'(ec << 2));
         for (int v = 1; v >= 0; v--) begin
            ext_val[1] <= v[0];
            step(8);
            rd(OFF_PIN_STATE);
            chk(q & 32'h2, 32'(v << 1), "pin state");
            chk(32'(port_irq), 32'(ec[1 - v]), "port irq");
            rd(OFF_PIN_FLAG);
            chk(q, 32'(ec[1 - v]) << 1, "flag");
            wr(OFF_PIN_FLAG, 32'h2);
            chk(32'(port_irq), 32'h0, "flag clear");
         end
      end
      chk(32'(irq), 32'h0, "masked");
      wr(OFF_IRQ_MASK, 32'h1);
      chk(32'(irq), 32'h1, "unmasked");
      rd(OFF_IRQ_STATUS);
      chk(q, 32'h1, "status");
      rd(OFF_IRQ_STATUS);
      chk({q[30:0], irq}, 32'h0, "read clear");
      $display("test interrupts done");
      wr(OFF_DATA_OUT, 32'h1);
      wr(OFF_HOLD, 32'h1);
      deep_sleep <= 1'b1;
      step(2);
      wr(OFF_DATA_OUT, 32'h0);
      chk(32'(pin_out[0]), 32'h1, "hold");
      deep_sleep <= 1'b0;
      step(2);
      chk(32'(pin_out[0]), 32'h1, "wake keep");
      rd(OFF_HOLD);
      chk(q, 32'h3, "retain");
      rd(OFF_IRQ_STATUS);
      chk(q, 32'h2, "wake event");
      wr(OFF_DATA_OUT, 32'h0);
      chk(32'(pin_out[0]), 32'h0, "new value");
      deep_sleep <= 1'b1;
      step(2);
      do_reset();
      chk(32'(pin_oe | pin_in_en | pin_pull_up), 32'h0,
         "reset wake");
      rd(OFF_HOLD);
      chk(q, 32'h0, "hold cleared");
      $display("test hold done");
      close_out();
   end
endmodule // gpio_port_with_retention_tb
